// ==== inc/iopc_pkg.sv ====
// Shared constants and types for the I/O port and converter control block.
package iopc_pkg;

    // ------------------------------------------------------------------
    // Register addresses, bit positions and reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_IOPORT = 7'h0E;
    localparam logic [6:0] ADDR_CONV = 7'h0F;
    localparam logic [6:0] ADDR_RESULT = 7'h11;
    localparam int IOP_EXT_LSB = 4;
    localparam int IOP_ITSDO_BIT = 3;
    localparam int CONV_START_BIT = 7;
    localparam int CONV_SEL_LSB = 4;
    localparam int CONV_REF_LSB = 2;
    localparam logic [3:0] IOPORT_RESET = 4'h0;
    localparam logic [6:0] CONV_RESET = 7'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Pin function codes, converter selections and full scale steps
    // ------------------------------------------------------------------
    localparam logic [4:0] FSEL_DIN = 5'h03;
    localparam logic [4:0] FSEL_EXT_FALL = 5'h04;
    localparam logic [4:0] FSEL_EXT_RISE = 5'h05;
    localparam logic [4:0] FSEL_EXT_ANY = 5'h06;
    localparam logic [4:0] FSEL_DOUT = 5'h0A;
    localparam logic [2:0] SEL_TEMP = 3'h0;
    localparam logic [2:0] SEL_PIN0 = 3'h1;
    localparam logic [2:0] SEL_PIN1 = 3'h2;
    localparam logic [2:0] SEL_PIN2 = 3'h3;
    localparam logic [2:0] SEL_D01 = 3'h4;
    localparam logic [2:0] SEL_D12 = 3'h5;
    localparam logic [2:0] SEL_D02 = 3'h6;
    localparam logic [2:0] SEL_GND = 3'h7;
    localparam logic [2:0] SRC_GND = 3'h0;
    localparam logic [2:0] SRC_TEMP = 3'h1;
    localparam logic [2:0] SRC_PIN0 = 3'h2;
    localparam logic [2:0] SRC_PIN1 = 3'h3;
    localparam logic [2:0] SRC_PIN2 = 3'h4;
    localparam logic [1:0] REF_BANDGAP = 2'h0;
    localparam logic [1:0] REF_THIRD = 2'h1;
    localparam logic [1:0] REF_HALF = 2'h2;
    localparam logic [6:0] FS_STEP_LOW = 7'h0E;
    localparam logic [6:0] FS_STEP_HIGH = 7'h15;

    // ------------------------------------------------------------------
    // Serial framing and timing
    // ------------------------------------------------------------------
    localparam logic [3:0] SPI_CMD_LAST = 4'h7;
    localparam logic [3:0] SPI_DATA_LAST = 4'hF;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 20000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_CONVERT = 2'b10
    } iopc_seq_state_e;

endpackage

// ==== rtl/iopc_conv_seq.sv ====
// Converter measurement sequencer: start, timed cycle, result capture, done flag.
module iopc_conv_seq #(
    parameter int CONV_CYCLES = iopc_pkg::CONV_CYCLES
) (
    input wire logic i_clk,          // System clock.
    input wire logic i_reset,        // Asynchronous reset, active high.
    input wire logic i_start,        // One-cycle start request.
    input wire logic [7:0] i_sample, // Converter output code.
    output logic o_busy,             // Measurement in progress.
    output logic o_done,             // Measurement finished.
    output logic [7:0] o_result      // Captured result.
);
    import iopc_pkg::*;

    localparam int CW = $clog2(CONV_CYCLES + 1);

    if (CONV_CYCLES < 1) begin : g_bad_cycles
        $error("CONV_CYCLES must be at least one");
    end

    iopc_seq_state_e state_q;
    logic [CW-1:0] cnt_q;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // A new start always restarts the cycle and drops the old done flag.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= SEQ_IDLE;
            cnt_q <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_result <= RESULT_RESET;
        end else if (i_start) begin
            state_q <= SEQ_CONVERT;
            cnt_q <= CW'(CONV_CYCLES - 1);
            o_busy <= 1'b1;
            o_done <= 1'b0;
        end else begin
            unique case (state_q)
                SEQ_IDLE: begin
                    o_busy <= 1'b0;
                end
                SEQ_CONVERT: begin
                    if (cnt_q == '0) begin
                        state_q <= SEQ_IDLE;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        o_result <= i_sample;
                    end else begin
                        cnt_q <= cnt_q - CW'(1);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_SEQ_START: assert property (@(posedge i_clk) disable iff (i_reset)
        i_start |=> o_busy && state_q == SEQ_CONVERT)
        else $error("start did not begin a measurement");
    AST_SEQ_DONE: assert property (@(posedge i_clk) disable iff (i_reset)
        o_busy && cnt_q == '0 && !i_start |=> o_done && !o_busy)
        else $error("done not raised at end of measurement");
    AST_SEQ_RESULT: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_done) |-> o_result == $past(i_sample))
        else $error("result not captured at completion");
    AST_SEQ_CLEAR: assert property (@(posedge i_clk) disable iff (i_reset)
        i_start |=> !o_done throughout o_busy [*1])
        else $error("stale done after new start");
    COV_SEQ_DONE: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_done));

endmodule // iopc_conv_seq

// ==== rtl/iopc_top.sv ====
// I/O port and converter control registers behind the serial register port.
// What this block does
// - Pin interrupt status readable at bits 6:4.
// - Interrupt request drives data out when deselected.
// - Digital output pins follow written direct bits.
// - Digital input pins read back live level.
// - Writing start bit begins a measurement.
// - Start bit reads one once measurement done.
// - Select codes 000-011 pick single-ended sources.
// - Codes 100-110 differential pairs, 111 ground.
// - Reference field picks bandgap, third, half supply.
// - Gain sets differential full scale per reference.
// - Function codes pick input, output, interrupt edges.
// - Completed measurement result readable at result register.
module iopc_top #(
    parameter int CONV_CYCLES = iopc_pkg::CONV_CYCLES
) (
    input wire logic i_clk,                    // System clock, 20 MHz.
    input wire logic i_reset,                  // Asynchronous reset, active high.
    input wire logic i_spi_sck,                // Serial clock pin.
    input wire logic i_spi_sdi,                // Serial data in pin.
    input wire logic i_chip_select_n,          // Chip select pin, active low.
    output logic o_sdo,                        // Serial data out level.
    output logic o_sdo_oe,                     // Serial data out enable.
    input wire logic i_interrupt_request_n,    // Chip interrupt request, active low.
    input wire logic [14:0] i_pin_function_select, // Function codes, 5 bits per pin.
    input wire logic [2:0] i_gpio,             // General purpose pin levels.
    output logic [2:0] o_gpio_out,             // General purpose pin drive level.
    output logic [2:0] o_gpio_oe,              // General purpose pin drive enable.
    input wire logic [7:0] i_conv_sample,      // Converter output code.
    output logic o_conv_busy,                  // Measurement in progress.
    output logic [2:0] o_conv_pos_src,         // Positive converter input source.
    output logic [2:0] o_conv_neg_src,         // Negative converter input source.
    output logic [1:0] o_conv_ref_sel,         // Converter reference choice.
    output logic o_conv_diff,                  // Differential input selected.
    output logic [6:0] o_conv_fs_milli         // Full scale in thousandths of supply.
);
    import iopc_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic sck_s1_q, sck_s2_q, sck_d_q;
    logic sdi_s1_q, sdi_s2_q;
    logic cs_s1_q, cs_s2_q;
    logic [2:0] gpio_s1_q, gpio_s2_q, gpio_d_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_d_q <= 1'b0;
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            gpio_s1_q <= 3'h0;
            gpio_s2_q <= 3'h0;
            gpio_d_q <= 3'h0;
        end else begin
            sck_s1_q <= i_spi_sck;
            sck_s2_q <= sck_s1_q;
            sck_d_q <= sck_s2_q;
            sdi_s1_q <= i_spi_sdi;
            sdi_s2_q <= sdi_s1_q;
            cs_s1_q <= i_chip_select_n;
            cs_s2_q <= cs_s1_q;
            gpio_s1_q <= i_gpio;
            gpio_s2_q <= gpio_s1_q;
            gpio_d_q <= gpio_s2_q;
        end
    end

    logic sck_rise, sck_fall;
    assign sck_rise = sck_s2_q & ~sck_d_q & ~cs_s2_q;
    assign sck_fall = ~sck_s2_q & sck_d_q & ~cs_s2_q;

    // ------------------------------------------------------------------
    // Serial frame: command byte then one data byte, MSB first
    // ------------------------------------------------------------------
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_in_q, shift_out_q, next_byte;
    logic [6:0] addr_q;
    logic wr_q, cmd_done, wr_stb, rd_clr;

    assign next_byte = {shift_in_q[6:0], sdi_s2_q};
    assign cmd_done = sck_rise && bit_cnt_q == SPI_CMD_LAST;
    assign wr_stb = sck_rise && bit_cnt_q == SPI_DATA_LAST && wr_q;
    assign rd_clr = cmd_done && !shift_in_q[6] && next_byte[6:0] == ADDR_IOPORT;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            bit_cnt_q <= 4'h0;
            shift_in_q <= 8'h00;
            addr_q <= 7'h00;
            wr_q <= 1'b0;
        end else if (cs_s2_q) begin
            bit_cnt_q <= 4'h0;
        end else if (sck_rise) begin
            shift_in_q <= next_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == SPI_CMD_LAST) begin
                wr_q <= shift_in_q[6];
                addr_q <= next_byte[6:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [3:0] ioport_q;
    logic [6:0] conv_q;
    logic start_req, conv_done;
    logic [7:0] conv_result;

    assign start_req = wr_stb && addr_q == ADDR_CONV && next_byte[CONV_START_BIT];

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ioport_q <= IOPORT_RESET;
            conv_q <= CONV_RESET;
        end else if (wr_stb) begin
            if (addr_q == ADDR_IOPORT) begin
                ioport_q <= next_byte[3:0];
            end
            if (addr_q == ADDR_CONV) begin
                conv_q <= next_byte[6:0];
            end
        end
    end

    iopc_conv_seq #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_seq (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_start(start_req),
        .i_sample(i_conv_sample),
        .o_busy(o_conv_busy),
        .o_done(conv_done),
        .o_result(conv_result)
    );

    // ------------------------------------------------------------------
    // Pins: function decode, edge status, direct I/O
    // ------------------------------------------------------------------
    logic [2:0] is_din, is_dout, ext_set, ext_status_q, dio_rd;

    for (genvar p = 0; p < 3; p++) begin : g_pin
        logic [4:0] fsel;
        logic rise, fall;
        assign fsel = i_pin_function_select[5*p+4:5*p];
        assign rise = gpio_s2_q[p] & ~gpio_d_q[p];
        assign fall = ~gpio_s2_q[p] & gpio_d_q[p];
        assign is_din[p] = fsel == FSEL_DIN;
        assign is_dout[p] = fsel == FSEL_DOUT;
        assign ext_set[p] = (fsel == FSEL_EXT_FALL && fall) || (fsel == FSEL_EXT_RISE && rise)
            || (fsel == FSEL_EXT_ANY && (rise || fall));
        assign dio_rd[p] = is_din[p] ? gpio_s2_q[p] : ioport_q[p];

        // Status is cleared by a read of the port register; a new edge wins.
        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                ext_status_q[p] <= 1'b0;
            end else if (ext_set[p]) begin
                ext_status_q[p] <= 1'b1;
            end else if (rd_clr) begin
                ext_status_q[p] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_gpio_out <= 3'h0;
            o_gpio_oe <= 3'h0;
        end else begin
            o_gpio_oe <= is_dout;
            o_gpio_out <= ioport_q[2:0] & is_dout;
        end
    end

    // ------------------------------------------------------------------
    // Read data and serial output
    // ------------------------------------------------------------------
    logic [7:0] rd_data;

    always_comb begin
        unique case (next_byte[6:0])
            ADDR_IOPORT: rd_data = {1'b0, ext_status_q, ioport_q[IOP_ITSDO_BIT], dio_rd};
            ADDR_CONV: rd_data = {conv_done, conv_q};
            ADDR_RESULT: rd_data = conv_result;
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            shift_out_q <= 8'h00;
        end else if (cs_s2_q) begin
            shift_out_q <= 8'h00;
        end else if (cmd_done && !shift_in_q[6]) begin
            shift_out_q <= rd_data;
        end else if (sck_fall && bit_cnt_q[3]) begin
            shift_out_q <= {shift_out_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else if (cs_s2_q) begin
            o_sdo_oe <= ioport_q[IOP_ITSDO_BIT];
            o_sdo <= ioport_q[IOP_ITSDO_BIT] & i_interrupt_request_n;
        end else begin
            o_sdo_oe <= 1'b1;
            if (sck_fall) begin
                o_sdo <= bit_cnt_q[3] & shift_out_q[7];
            end
        end
    end

    // ------------------------------------------------------------------
    // Converter input, reference and full scale decode
    // ------------------------------------------------------------------
    logic [2:0] sel;
    logic [1:0] rsel, gain;
    logic [6:0] step;

    assign sel = conv_q[CONV_SEL_LSB+2:CONV_SEL_LSB];
    assign rsel = conv_q[CONV_REF_LSB+1:CONV_REF_LSB];
    assign gain = conv_q[1:0];
    assign step = rsel[0] ? FS_STEP_HIGH : FS_STEP_LOW;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_conv_pos_src <= SRC_TEMP;
            o_conv_neg_src <= SRC_GND;
            o_conv_diff <= 1'b0;
        end else begin
            o_conv_diff <= sel == SEL_D01 || sel == SEL_D12 || sel == SEL_D02;
            unique case (sel)
                SEL_TEMP: {o_conv_pos_src, o_conv_neg_src} <= {SRC_TEMP, SRC_GND};
                SEL_PIN0: {o_conv_pos_src, o_conv_neg_src} <= {SRC_PIN0, SRC_GND};
                SEL_PIN1: {o_conv_pos_src, o_conv_neg_src} <= {SRC_PIN1, SRC_GND};
                SEL_PIN2: {o_conv_pos_src, o_conv_neg_src} <= {SRC_PIN2, SRC_GND};
                SEL_D01: {o_conv_pos_src, o_conv_neg_src} <= {SRC_PIN0, SRC_PIN1};
                SEL_D12: {o_conv_pos_src, o_conv_neg_src} <= {SRC_PIN1, SRC_PIN2};
                SEL_D02: {o_conv_pos_src, o_conv_neg_src} <= {SRC_PIN0, SRC_PIN2};
                SEL_GND: {o_conv_pos_src, o_conv_neg_src} <= {SRC_GND, SRC_GND};
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_conv_ref_sel <= REF_BANDGAP;
            o_conv_fs_milli <= 7'h00;
        end else begin
            o_conv_ref_sel <= !rsel[1] ? REF_BANDGAP : (rsel[0] ? REF_HALF : REF_THIRD);
            o_conv_fs_milli <= (sel == SEL_D01 || sel == SEL_D12 || sel == SEL_D02)
                ? 7'(step * ({5'h00, gain} + 7'h01)) : 7'h00;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_EXT_SET: assert property (@(posedge i_clk) disable iff (i_reset)
        ext_set != 3'h0 |=> (ext_status_q & $past(ext_set)) == $past(ext_set))
        else $error("interrupt status not set by edge");
    AST_SDO_IRQ: assert property (@(posedge i_clk) disable iff (i_reset)
        cs_s2_q && ioport_q[IOP_ITSDO_BIT] |=> o_sdo_oe && o_sdo == $past(i_interrupt_request_n))
        else $error("interrupt request not on data out");
    AST_DOUT_DRIVE: assert property (@(posedge i_clk) disable iff (i_reset)
        ##1 (o_gpio_oe == $past(is_dout)) && ((o_gpio_out & o_gpio_oe) == $past(ioport_q[2:0] & is_dout)))
        else $error("output pin does not follow direct bit");
    AST_DIN_READ: assert property (@(posedge i_clk) disable iff (i_reset)
        next_byte[6:0] == ADDR_IOPORT |-> (rd_data[2:0] & is_din) == (gpio_s2_q & is_din))
        else $error("input pin level not read back");
    AST_SEL_SINGLE: assert property (@(posedge i_clk) disable iff (i_reset)
        sel == SEL_PIN2 |=> o_conv_pos_src == SRC_PIN2 && o_conv_neg_src == SRC_GND && !o_conv_diff)
        else $error("single-ended select wrong");
    AST_SEL_DIFF: assert property (@(posedge i_clk) disable iff (i_reset)
        sel == SEL_D12 |=> o_conv_pos_src == SRC_PIN1 && o_conv_neg_src == SRC_PIN2 && o_conv_diff)
        else $error("differential select wrong");
    AST_REF: assert property (@(posedge i_clk) disable iff (i_reset)
        rsel == 2'h2 |=> o_conv_ref_sel == REF_THIRD)
        else $error("reference select wrong");
    AST_FS: assert property (@(posedge i_clk) disable iff (i_reset)
        sel == SEL_D01 && rsel[0] && gain == 2'h3 |=> o_conv_fs_milli == 7'h54)
        else $error("full scale value wrong");
    AST_DONE_READ: assert property (@(posedge i_clk) disable iff (i_reset)
        start_req |=> !rd_data[CONV_START_BIT] || next_byte[6:0] != ADDR_CONV)
        else $error("stale done visible after start");
    COV_START: cover property (@(posedge i_clk) disable iff (i_reset) start_req);
    COV_EXT: cover property (@(posedge i_clk) disable iff (i_reset) $rose(ext_status_q[2]));
    COV_SDO_IRQ: cover property (@(posedge i_clk) disable iff (i_reset) cs_s2_q && o_sdo_oe && !o_sdo);

endmodule // iopc_top

// ==== sim/iopc_host.sv ====
// Host microcontroller model that drives the serial register port.
module iopc_host (
    input wire logic i_clk, // System clock.
    input wire logic i_sdo, // Serial data out of the device.
    output logic o_sck,     // Serial clock, idle low.
    output logic o_sdi,     // Serial data in of the device.
    output logic o_cs_n     // Chip select, active low.
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 4;
    initial begin
        o_sck = 1'b0;
        o_sdi = 1'b0;
        o_cs_n = 1'b1;
    end
    // One frame: direction bit, address, data, each phase HALF clocks long.
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] frame;
        frame = {wr, addr, wd};
        rd = 8'h00;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (HALF) @(posedge i_clk);
            o_sdi <= frame[i];
            repeat (HALF) @(posedge i_clk);
            o_sck <= 1'b1;
            if (i < 8) begin
                rd[i] = i_sdo;
            end
            repeat (HALF) @(posedge i_clk);
            o_sck <= 1'b0;
        end
        repeat (HALF) @(posedge i_clk);
        o_cs_n <= 1'b1;
        // A released data line must not keep showing its last bit.
        o_sdi <= ~frame[0];
        repeat (HALF) @(posedge i_clk);
    endtask
endmodule // iopc_host

// ==== sim/tb.sv ====
// Self-checking testbench for the I/O port and converter control block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iopc_pkg::*;
    localparam int CONV_N = 400;
    logic clk, rst, sck, sdi, cs_n, sdo, sdo_oe, irq_n, busy, diff;
    logic [14:0] fsel;
    logic [2:0] gpio, g_out, g_oe, pos, neg;
    logic [7:0] sample, rd;
    logic [1:0] ref_sel;
    logic [6:0] fs;
    logic [2:0] pos_tab [8] = '{SRC_TEMP, SRC_PIN0, SRC_PIN1, SRC_PIN2, SRC_PIN0, SRC_PIN1, SRC_PIN0, SRC_GND};
    logic [2:0] neg_tab [8] = '{SRC_GND, SRC_GND, SRC_GND, SRC_GND, SRC_PIN1, SRC_PIN2, SRC_PIN2, SRC_GND};
    int err_total = 0;
    int n_checks = 0;
    iopc_top #(.CONV_CYCLES(CONV_N)) i_dut (.i_clk(clk), .i_reset(rst), .i_spi_sck(sck), .i_spi_sdi(sdi),
        .i_chip_select_n(cs_n), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_interrupt_request_n(irq_n),
        .i_pin_function_select(fsel), .i_gpio(gpio), .o_gpio_out(g_out), .o_gpio_oe(g_oe),
        .i_conv_sample(sample), .o_conv_busy(busy), .o_conv_pos_src(pos), .o_conv_neg_src(neg),
        .o_conv_ref_sel(ref_sel), .o_conv_diff(diff), .o_conv_fs_milli(fs));
    iopc_host i_host (.i_clk(clk), .i_sdo(sdo), .o_sck(sck), .o_sdi(sdi), .o_cs_n(cs_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, d, rd);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp, input string name);
        i_host.xfer(1'b0, a, 8'h00, rd);
        chk(name, exp, rd);
    endtask
    task automatic t_reset();
        rdc(ADDR_IOPORT, 8'h00, "ioport reset");
        rdc(ADDR_CONV, 8'h00, "conv reset");
        rdc(7'h2A, 8'h00, "unmapped");
    endtask
    task automatic t_dio();
        fsel <= {FSEL_DOUT, FSEL_DIN, 5'h00};
        gpio <= 3'b010;
        wr(ADDR_IOPORT, 8'hF5);
        chk("gpio oe", 8'h04, {5'h00, g_oe});
        chk("gpio out", 8'h04, {5'h00, g_out});
        rdc(ADDR_IOPORT, 8'h07, "din high");
        gpio <= 3'b000;
        rdc(ADDR_IOPORT, 8'h05, "din low");
    endtask
    task automatic t_ext();
        logic [4:0] codes [3] = '{FSEL_EXT_FALL, FSEL_EXT_RISE, FSEL_EXT_ANY};
        for (int c = 0; c < 3; c++) begin
            fsel <= {10'h000, codes[c]};
            rdc(ADDR_IOPORT, 8'h05, "clear");
            gpio <= 3'b001;
            rdc(ADDR_IOPORT, (c > 0) ? 8'h15 : 8'h05, "ext rise");
            gpio <= 3'b000;
            rdc(ADDR_IOPORT, (c != 1) ? 8'h15 : 8'h05, "ext fall");
        end
    endtask
    task automatic t_sdo();
        wr(ADDR_IOPORT, 8'h08);
        for (int v = 0; v < 2; v++) begin
            irq_n <= v[0];
            repeat (3) @(posedge clk);
            chk("sdo oe", 8'h01, {7'h00, sdo_oe});
            chk("sdo irq", {7'h00, v[0]}, {7'h00, sdo});
        end
        wr(ADDR_IOPORT, 8'h00);
        chk("sdo off", 8'h00, {7'h00, sdo_oe});
    endtask
    task automatic t_conv();
        logic [2:0] s;
        logic [1:0] r, g;
        for (int k = 0; k < 8; k++) begin
            s = k[2:0];
            r = s[1:0];
            g = s[2:1];
            wr(ADDR_CONV, {1'b0, s, r, g});
            chk("pos src", {5'h00, pos_tab[k]}, {5'h00, pos});
            chk("neg src", {5'h00, neg_tab[k]}, {5'h00, neg});
            chk("diff", {7'h00, (k > 3 && k < 7)}, {7'h00, diff});
            chk("ref", {6'h00, r[1] ? (r[0] ? REF_HALF : REF_THIRD) : REF_BANDGAP}, {6'h00, ref_sel});
            chk("fs", (k > 3 && k < 7) ? (g + 8'h01) * (r[0] ? 8'h15 : 8'h0E) : 8'h00, {1'b0, fs});
        end
        for (int n = 0; n < 2; n++) begin
            sample <= n[0] ? 8'h3C : 8'hA5;
            wr(ADDR_CONV, 8'hDB);
            chk("busy", 8'h01, {7'h00, busy});
            rdc(ADDR_CONV, 8'h5B, "done clear");
            for (int w = 0; w < CONV_N + 10 && busy !== 1'b0; w++) begin
                @(posedge clk);
            end
            rdc(ADDR_CONV, 8'hDB, "done set");
            rdc(ADDR_RESULT, sample, "result");
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        irq_n = 1'b1;
        fsel = 15'h0000;
        gpio = 3'b000;
        sample = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_dio();
        t_ext();
        t_sdo();
        t_conv();
        final_report();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule // tb
